// [design/dsg_gate_sel.sv]
// Per-unit clock enable selection and bus fault detection
`timescale 1ns/1ps
module dsg_gate_sel (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Gating bits of the three sets
  input  wire logic run_en,
  input  wire logic sleep_en,
  input  wire logic deep_en,
  // Power state
  input  wire logic sleep_mode,
  input  wire logic deep_sleep_mode,
  input  wire logic auto_clock_gating,
  // Bus access aimed at this unit
  input  wire logic access,
  // Results
  output logic      clk_en_q,
  output logic      fault_q
);

  logic clk_en_d;
  logic fault_d;

  // Deep-sleep set wins over sleep set; both need auto gating
  always_comb
  begin
    if (auto_clock_gating && deep_sleep_mode)
      clk_en_d = deep_en;
    else if (auto_clock_gating && sleep_mode)
      clk_en_d = sleep_en;
    else
      clk_en_d = run_en;
  end

  // Access to an unclocked unit faults
  assign fault_d = access & ~clk_en_q;

  always_ff @(posedge mclk)
  begin
    if (rst)
      clk_en_q <= 1'b0;
    else
      clk_en_q <= clk_en_d;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      fault_q <= 1'b0;
    else
      fault_q <= fault_d;
  end

endmodule

// [design/dsg_pkg.sv]
// Constants for the deep-sleep clock gating block
package dsg_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register offsets
  localparam logic [11:0] OFF_RUN_CLOCK_CONFIG    = 12'h060;
  localparam logic [11:0] OFF_RUN_CLOCK_GATE_0    = 12'h100;
  localparam logic [11:0] OFF_SLEEP_CLOCK_GATE_0  = 12'h110;
  localparam logic [11:0] OFF_DEEP_SLEEP_CLOCK_GATE_0 = 12'h120;
  localparam logic [11:0] OFF_INT_STATUS          = 12'h150;
  localparam logic [11:0] OFF_INT_MASK            = 12'h154;

  // Gated units, one index per peripheral
  localparam int unsigned NUM_UNITS     = 2;
  localparam int unsigned UNIT_WATCHDOG = 0;
  localparam int unsigned UNIT_ADC      = 1;

  // Field positions in the gating registers
  localparam int unsigned BIT_WATCHDOG_CLOCK_ENABLE = 3;
  localparam int unsigned BIT_ADC_CLOCK_ENABLE      = 16;
  localparam logic [31:0] GATE_WMASK = 32'h0001_0008;

  // Auto clock gating bit in the run clock configuration register
  localparam int unsigned BIT_AUTO_CLOCK_GATING = 27;
  localparam logic [31:0] CFG_WMASK = 32'h0800_0000;

  // Interrupt status and mask layout
  localparam logic [31:0] INT_WMASK = 32'h0000_0003;

  // Values after reset
  localparam logic [31:0] GATE_RST   = 32'h0000_0040;
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [31:0] INT_RST    = 32'h0000_0000;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

endpackage

// [design/dsg_top.sv]
// Deep-sleep clock gating control with run and sleep sets and fault interrupt
//
// Contract
// - Set bit clocks unit; clear bit stops it
// - Access to unclocked unit answers bus fault
// - Gating enables come out of reset cleared
// - Deep-sleep register reset value reads 0x00000040
// - Converter enable bit 16, watchdog bit 3
// - Separate run, sleep and deep-sleep sets
// - Sleep sets apply only with auto gating
// - Reserved bits read-only, read zero
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module dsg_top (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Power state from the core
  input  wire logic        sleep_mode,
  input  wire logic        deep_sleep_mode,
  // Bus accesses aimed at the gated units, bit 0 watchdog, bit 1 converter
  input  wire logic [1:0]  periph_access,
  // Unit clock enables and faults
  output logic      [1:0]  periph_clk_en,
  output logic      [1:0]  periph_fault,
  output logic             bus_fault,
  // Interrupt
  output logic             irq
);

  logic [31:0] run_clock_gate_0_q;
  logic [31:0] sleep_clock_gate_0_q;
  logic [31:0] deep_sleep_clock_gate_0_q;
  logic [31:0] run_clock_config_q;
  logic [31:0] int_status_q;
  logic [31:0] int_mask_q;
  logic [31:0] reg_rdata_q;
  logic [31:0] reg_rdata_d;
  logic [31:0] int_status_d;
  logic [31:0] int_mask_d;
  logic        irq_q;
  logic        auto_clock_gating;
  logic [1:0]  run_bits;
  logic [1:0]  sleep_bits;
  logic [1:0]  deep_bits;
  logic        wr_run;
  logic        wr_sleep;
  logic        wr_deep;
  logic        wr_cfg;
  logic        wr_stat;
  logic        wr_mask;

  // Write decode
  assign wr_run   = reg_wr && (reg_addr == dsg_pkg::OFF_RUN_CLOCK_GATE_0);
  assign wr_sleep = reg_wr && (reg_addr == dsg_pkg::OFF_SLEEP_CLOCK_GATE_0);
  assign wr_deep  = reg_wr && (reg_addr == dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0);
  assign wr_cfg   = reg_wr && (reg_addr == dsg_pkg::OFF_RUN_CLOCK_CONFIG);
  assign wr_stat  = reg_wr && (reg_addr == dsg_pkg::OFF_INT_STATUS);
  assign wr_mask  = reg_wr && (reg_addr == dsg_pkg::OFF_INT_MASK);

  assign auto_clock_gating = run_clock_config_q[dsg_pkg::BIT_AUTO_CLOCK_GATING];

  // Gating registers: only enable fields take writes, rest keeps reset value
  always_ff @(posedge mclk)
  begin
    if (rst)
      run_clock_gate_0_q <= dsg_pkg::GATE_RST;
    else if (wr_run)
      run_clock_gate_0_q <= (run_clock_gate_0_q & ~dsg_pkg::GATE_WMASK)
                            | (reg_wdata & dsg_pkg::GATE_WMASK);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      sleep_clock_gate_0_q <= dsg_pkg::GATE_RST;
    else if (wr_sleep)
      sleep_clock_gate_0_q <= (sleep_clock_gate_0_q & ~dsg_pkg::GATE_WMASK)
                              | (reg_wdata & dsg_pkg::GATE_WMASK);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      deep_sleep_clock_gate_0_q <= dsg_pkg::GATE_RST;
    else if (wr_deep)
      deep_sleep_clock_gate_0_q <= (deep_sleep_clock_gate_0_q & ~dsg_pkg::GATE_WMASK)
                                   | (reg_wdata & dsg_pkg::GATE_WMASK);
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      run_clock_config_q <= dsg_pkg::CFG_RST;
    else if (wr_cfg)
      run_clock_config_q <= reg_wdata & dsg_pkg::CFG_WMASK;
  end

  // Field extraction, index order follows the unit numbering
  assign run_bits   = {run_clock_gate_0_q[dsg_pkg::BIT_ADC_CLOCK_ENABLE],
                       run_clock_gate_0_q[dsg_pkg::BIT_WATCHDOG_CLOCK_ENABLE]};
  assign sleep_bits = {sleep_clock_gate_0_q[dsg_pkg::BIT_ADC_CLOCK_ENABLE],
                       sleep_clock_gate_0_q[dsg_pkg::BIT_WATCHDOG_CLOCK_ENABLE]};
  assign deep_bits  = {deep_sleep_clock_gate_0_q[dsg_pkg::BIT_ADC_CLOCK_ENABLE],
                       deep_sleep_clock_gate_0_q[dsg_pkg::BIT_WATCHDOG_CLOCK_ENABLE]};

  // One selector per gated unit
  genvar gi;
  generate
    for (gi = 0; gi < dsg_pkg::NUM_UNITS; gi++)
    begin : g_unit
      dsg_gate_sel u_sel (
        .mclk              (mclk),
        .rst               (rst),
        .run_en            (run_bits[gi]),
        .sleep_en          (sleep_bits[gi]),
        .deep_en           (deep_bits[gi]),
        .sleep_mode        (sleep_mode),
        .deep_sleep_mode   (deep_sleep_mode),
        .auto_clock_gating (auto_clock_gating),
        .access            (periph_access[gi]),
        .clk_en_q          (periph_clk_en[gi]),
        .fault_q           (periph_fault[gi])
      );
    end
  endgenerate

  assign bus_fault = |periph_fault;

  // Sticky fault status; a new fault wins over a write-one clear
  always_comb
  begin
    int_status_d = int_status_q;
    if (wr_stat)
      int_status_d = int_status_d & ~(reg_wdata & dsg_pkg::INT_WMASK);
    int_status_d[1:0] = int_status_d[1:0] | periph_fault;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      int_status_q <= dsg_pkg::INT_RST;
    else
      int_status_q <= int_status_d;
  end

  // Mask next value also drives the interrupt, so a mask write acts at once
  always_comb
  begin
    int_mask_d = int_mask_q;
    if (wr_mask)
      int_mask_d = reg_wdata & dsg_pkg::INT_WMASK;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      int_mask_q <= dsg_pkg::INT_RST;
    else
      int_mask_q <= int_mask_d;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      irq_q <= 1'b0;
    else
      irq_q <= |(int_status_d & int_mask_d);
  end

  assign irq = irq_q;

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    reg_rdata_d = dsg_pkg::RDATA_IDLE;
    if (reg_rd)
    begin
      unique case (reg_addr)
        dsg_pkg::OFF_RUN_CLOCK_CONFIG:        reg_rdata_d = run_clock_config_q;
        dsg_pkg::OFF_RUN_CLOCK_GATE_0:        reg_rdata_d = run_clock_gate_0_q;
        dsg_pkg::OFF_SLEEP_CLOCK_GATE_0:      reg_rdata_d = sleep_clock_gate_0_q;
        dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0: reg_rdata_d = deep_sleep_clock_gate_0_q;
        dsg_pkg::OFF_INT_STATUS:              reg_rdata_d = int_status_q;
        dsg_pkg::OFF_INT_MASK:                reg_rdata_d = int_mask_q;
        default:                              reg_rdata_d = dsg_pkg::RDATA_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      reg_rdata_q <= dsg_pkg::RDATA_IDLE;
    else
      reg_rdata_q <= reg_rdata_d;
  end

  assign reg_rdata = reg_rdata_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_deep_select: assert property (
    (auto_clock_gating && deep_sleep_mode) |=> (periph_clk_en == $past(deep_bits)))
    else $error("deep-sleep set not applied");

  a_sleep_select: assert property (
    (auto_clock_gating && sleep_mode && !deep_sleep_mode) |=> (periph_clk_en == $past(sleep_bits)))
    else $error("sleep set not applied");

  a_run_select: assert property (
    !auto_clock_gating |=> (periph_clk_en == $past(run_bits)))
    else $error("run set not applied without auto gating");

  a_fault_raise: assert property (
    ((periph_access & ~periph_clk_en) != 2'b00) |=> bus_fault)
    else $error("missing bus fault on gated unit");

  a_fault_quiet: assert property (
    ((periph_access & ~periph_clk_en) == 2'b00) |=> !bus_fault)
    else $error("spurious bus fault");

  a_reset_state: assert property (
    $past(rst) |-> (periph_clk_en == 2'b00 && deep_sleep_clock_gate_0_q == dsg_pkg::GATE_RST))
    else $error("wrong state after reset");

  a_field_write: assert property (
    wr_deep |=> (deep_bits == {$past(reg_wdata[16]), $past(reg_wdata[3])}))
    else $error("deep-sleep enable fields not written");

  a_reserved_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0)
    |=> ((reg_rdata & ~(dsg_pkg::GATE_WMASK | dsg_pkg::GATE_RST)) == 32'h0000_0000))
    else $error("reserved bits read non-zero");

  a_read_slot: assert property (
    !reg_rd |=> (reg_rdata == 32'h0000_0000))
    else $error("read data outside its slot");

  a_fault_sticky: assert property (
    bus_fault |=> ((int_status_q[1:0] & $past(periph_fault)) == $past(periph_fault)))
    else $error("fault not captured in status");

  a_run_write: assert property (
    wr_run |=> (run_bits == {$past(reg_wdata[dsg_pkg::BIT_ADC_CLOCK_ENABLE]),
                             $past(reg_wdata[dsg_pkg::BIT_WATCHDOG_CLOCK_ENABLE])}))
    else $error("run enable fields not written");

  a_sleep_write: assert property (
    wr_sleep |=> (sleep_bits == {$past(reg_wdata[dsg_pkg::BIT_ADC_CLOCK_ENABLE]),
                                 $past(reg_wdata[dsg_pkg::BIT_WATCHDOG_CLOCK_ENABLE])}))
    else $error("sleep enable fields not written");

  a_cfg_write: assert property (
    wr_cfg |=> (auto_clock_gating == $past(reg_wdata[dsg_pkg::BIT_AUTO_CLOCK_GATING])))
    else $error("auto gating bit not written");

  a_deep_hold: assert property (
    !wr_deep |=> $stable(deep_sleep_clock_gate_0_q))
    else $error("deep-sleep register changed without a write");

  a_run_fixed: assert property (
    (run_clock_gate_0_q & ~dsg_pkg::GATE_WMASK) == (dsg_pkg::GATE_RST & ~dsg_pkg::GATE_WMASK))
    else $error("run register read-only bits changed");

  a_sleep_fixed: assert property (
    (sleep_clock_gate_0_q & ~dsg_pkg::GATE_WMASK) == (dsg_pkg::GATE_RST & ~dsg_pkg::GATE_WMASK))
    else $error("sleep register read-only bits changed");

  a_deep_fixed: assert property (
    (deep_sleep_clock_gate_0_q & ~dsg_pkg::GATE_WMASK) == (dsg_pkg::GATE_RST & ~dsg_pkg::GATE_WMASK))
    else $error("deep-sleep register read-only bits changed");

  a_cfg_reserved: assert property (
    (run_clock_config_q & ~dsg_pkg::CFG_WMASK) == 32'h0000_0000)
    else $error("reserved config bits set");

  a_enable_reset: assert property (
    $past(rst) |-> (run_bits == 2'b00 && sleep_bits == 2'b00 && deep_bits == 2'b00))
    else $error("gating enables not cleared by reset");

  a_output_reset: assert property (
    $past(rst) |-> (periph_fault == 2'b00 && !irq && reg_rdata == 32'h0000_0000))
    else $error("outputs not cleared by reset");

  a_fault_pulse: assert property (
    (periph_access != 2'b00) |=> (periph_fault == ($past(periph_access) & ~$past(periph_clk_en))))
    else $error("unit fault does not match gated access");

  a_access_ok: assert property (
    ((periph_access & periph_clk_en) != 2'b00)
    |=> ((periph_fault & $past(periph_access) & $past(periph_clk_en)) == 2'b00))
    else $error("fault on a clocked unit");

  a_deep_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0)
    |=> (reg_rdata == $past(deep_sleep_clock_gate_0_q)))
    else $error("deep-sleep register read wrong");

  a_run_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_RUN_CLOCK_GATE_0)
    |=> (reg_rdata == $past(run_clock_gate_0_q)))
    else $error("run register read wrong");

  a_sleep_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_SLEEP_CLOCK_GATE_0)
    |=> (reg_rdata == $past(sleep_clock_gate_0_q)))
    else $error("sleep register read wrong");

  a_cfg_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_RUN_CLOCK_CONFIG)
    |=> (reg_rdata == $past(run_clock_config_q)))
    else $error("config register read wrong");

  a_status_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_INT_STATUS)
    |=> (reg_rdata == $past(int_status_q)))
    else $error("status register read wrong");

  a_mask_read: assert property (
    (reg_rd && reg_addr == dsg_pkg::OFF_INT_MASK)
    |=> (reg_rdata == $past(int_mask_q)))
    else $error("mask register read wrong");

  a_status_clear: assert property (
    (wr_stat && periph_fault == 2'b00)
    |=> ((int_status_q & $past(reg_wdata) & dsg_pkg::INT_WMASK) == 32'h0000_0000))
    else $error("status bit not cleared by write of one");

  a_status_hold: assert property (
    !wr_stat |=> ((int_status_q & $past(int_status_q)) == $past(int_status_q)))
    else $error("status bit lost without a clear");

  a_mask_write: assert property (
    wr_mask |=> (int_mask_q == ($past(reg_wdata) & dsg_pkg::INT_WMASK)))
    else $error("mask register not written");

  a_irq_level: assert property (
    irq == |(int_status_q & int_mask_q))
    else $error("interrupt does not follow masked status");

  a_read_unmapped: assert property (
    (reg_rd && reg_addr != dsg_pkg::OFF_RUN_CLOCK_CONFIG && reg_addr != dsg_pkg::OFF_RUN_CLOCK_GATE_0
     && reg_addr != dsg_pkg::OFF_SLEEP_CLOCK_GATE_0 && reg_addr != dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0
     && reg_addr != dsg_pkg::OFF_INT_STATUS && reg_addr != dsg_pkg::OFF_INT_MASK)
    |=> (reg_rdata == 32'h0000_0000))
    else $error("unmapped read returned data");

endmodule

// [tb/testbench.sv]
// Self-checking bench for the deep-sleep clock gating block
`timescale 1ns/1ps
module testbench;
  logic        mclk;
  logic        rst;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        sleep_mode;
  logic        deep_sleep_mode;
  logic [1:0]  periph_access;
  logic [1:0]  periph_clk_en;
  logic [1:0]  periph_fault;
  logic        bus_fault;
  logic        irq;
  int          mismatches;
  int          samples_checked;
  int          cycles;

  dsg_top u_dsg_top (
    .mclk            (mclk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .sleep_mode      (sleep_mode),
    .deep_sleep_mode (deep_sleep_mode),
    .periph_access   (periph_access),
    .periph_clk_en   (periph_clk_en),
    .periph_fault    (periph_fault),
    .bus_fault       (bus_fault),
    .irq             (irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic read_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    reg_read(a, d);
    chk(d, exp);
  endtask

  // One access cycle, then fault outputs in the following cycle
  task automatic access(input logic [1:0] acc, input logic [1:0] exp_f);
    @(posedge mclk);
    periph_access <= acc;
    @(posedge mclk);
    periph_access <= 2'h0;
    #1;
    chk({30'h0, periph_fault}, {30'h0, exp_f});
    chk({31'h0, bus_fault}, {31'h0, |exp_f});
  endtask

  task automatic mode_chk(input logic s, input logic d, input logic [1:0] exp);
    @(posedge mclk);
    sleep_mode      <= s;
    deep_sleep_mode <= d;
    repeat (2) @(posedge mclk);
    #1 chk({30'h0, periph_clk_en}, {30'h0, exp});
  endtask

  initial
  begin
    cycles = 0;
    mismatches = 0;
    samples_checked = 0;
    rst = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sleep_mode = 1'b0;
    deep_sleep_mode = 1'b0;
    periph_access = 2'h0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    #1 chk({30'h0, periph_clk_en}, 32'h0000_0000);
    read_chk(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
    read_chk(dsg_pkg::OFF_RUN_CLOCK_GATE_0, 32'h0000_0040);
    read_chk(dsg_pkg::OFF_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
    @(posedge mclk);
    #1 chk(reg_rdata, 32'h0000_0000);
    read_chk(12'h7fc, 32'h0000_0000);
    reg_write(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'hffff_ffff);
    read_chk(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0001_0048);
    reg_write(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0000_0000);
    read_chk(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
    // Faults on both unclocked units, converter masked in
    reg_write(dsg_pkg::OFF_INT_MASK, 32'h0000_0002);
    access(2'h3, 2'h3);
    @(posedge mclk);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    read_chk(dsg_pkg::OFF_INT_STATUS, 32'h0000_0003);
    reg_write(dsg_pkg::OFF_INT_STATUS, 32'h0000_0002);
    read_chk(dsg_pkg::OFF_INT_STATUS, 32'h0000_0001);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    reg_write(dsg_pkg::OFF_INT_STATUS, 32'h0000_0001);
    read_chk(dsg_pkg::OFF_INT_STATUS, 32'h0000_0000);
    // Run set clocks the watchdog only
    reg_write(dsg_pkg::OFF_RUN_CLOCK_GATE_0, 32'h0000_0008);
    @(posedge mclk);
    #1 chk({30'h0, periph_clk_en}, 32'h0000_0001);
    access(2'h1, 2'h0);
    access(2'h2, 2'h2);
    reg_write(dsg_pkg::OFF_SLEEP_CLOCK_GATE_0, 32'h0001_0048);
    reg_write(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0001_0000);
    read_chk(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0001_0040);
    mode_chk(1'b0, 1'b1, 2'h1);
    mode_chk(1'b1, 1'b0, 2'h1);
    reg_write(dsg_pkg::OFF_RUN_CLOCK_CONFIG, 32'hffff_ffff);
    read_chk(dsg_pkg::OFF_RUN_CLOCK_CONFIG, 32'h0800_0000);
    mode_chk(1'b0, 1'b1, 2'h2);
    access(2'h3, 2'h1);
    mode_chk(1'b1, 1'b0, 2'h3);
    mode_chk(1'b1, 1'b1, 2'h2);
    mode_chk(1'b0, 1'b0, 2'h1);
    // Fault and write-one clear in the same cycle: the fault wins
    reg_write(dsg_pkg::OFF_INT_STATUS, 32'h0000_0003);
    fork
      access(2'h2, 2'h2);
      begin
        @(posedge mclk);
        reg_write(dsg_pkg::OFF_INT_STATUS, 32'h0000_0002);
      end
    join
    read_chk(dsg_pkg::OFF_INT_STATUS, 32'h0000_0002);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    // Reset in mid-run returns the run and deep-sleep sets to their reset state
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk({30'h0, periph_clk_en}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    read_chk(dsg_pkg::OFF_DEEP_SLEEP_CLOCK_GATE_0, 32'h0000_0040);
    read_chk(dsg_pkg::OFF_RUN_CLOCK_GATE_0, 32'h0000_0040);
    read_chk(dsg_pkg::OFF_RUN_CLOCK_CONFIG, 32'h0000_0000);
    read_chk(dsg_pkg::OFF_INT_STATUS, 32'h0000_0000);
    print_verdict();
  end
endmodule
